//--- hdl/chg_pkg.sv
// Package with constants and types of the charger control logic.
package chg_pkg;
  // Clock rate in MHz.
  localparam int unsigned CLK_MHZ = 100;
  // Timing figures in their own units.
  localparam int unsigned ALERT_US = 256;
  localparam int unsigned SHIP_EXIT_MS = 1000;
  localparam int unsigned PB_RESET_MS = 10000;
  localparam int unsigned SW_OFF_MS = 300;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned DET_STEP_US = 40;
  // Cycle counts derived from the clock rate.
  localparam int unsigned ALERT_CYC = ALERT_US * CLK_MHZ;
  localparam int unsigned SHIP_EXIT_CYC = SHIP_EXIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned PB_RESET_CYC = PB_RESET_MS * 1000 * CLK_MHZ;
  localparam int unsigned SW_OFF_CYC = SW_OFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned DET_STEP_CYC = DET_STEP_US * CLK_MHZ;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_THERM = 8'h08;
  localparam logic [7:0] REG_SYSMIN = 8'h0c;
  localparam logic [7:0] REG_ADC = 8'h10;
  localparam logic [7:0] REG_HVREQ = 8'h24;
  // Control register field positions.
  localparam int CTRL_CHG_BIT = 0;
  localparam int CTRL_BOOST_BIT = 1;
  localparam int CTRL_STATDIS_BIT = 2;
  localparam int CTRL_SHIP_BIT = 3;
  localparam int CTRL_ADC_BIT = 4;
  // Values after reset.
  localparam logic [4:0] CTRL_RST = 5'h13;
  localparam logic [6:0] THERM_RST = 7'h78;
  localparam logic [6:0] SYSMIN_RST = 7'h23;
  // Default input limit codes per source, in 50 mA steps.
  localparam logic [7:0] ILIM_NONE = 8'h0a;
  localparam logic [7:0] ILIM_SDP = 8'h0a;
  localparam logic [7:0] ILIM_CDP = 8'h1e;
  localparam logic [7:0] ILIM_DCP = 8'h41;
  // Charge cycle phases.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_PRE = 3'b001,
    PH_CC = 3'b010,
    PH_CV = 3'b011,
    PH_DONE = 3'b100
  } chg_phase_t;
  // Source detection steps.
  typedef enum logic [2:0] {
    DT_IDLE = 3'b000,
    DT_DCD = 3'b001,
    DT_PRI = 3'b010,
    DT_SEC = 3'b011,
    DT_DONE = 3'b100
  } chg_det_t;
  // Detected source type.
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_SDP = 2'b01,
    SRC_CDP = 2'b10,
    SRC_DCP = 2'b11
  } chg_src_t;
  // Comparator flags from the analog front end.
  typedef struct packed {
    logic supply_ok;
    logic below_pre;
    logic below_cv;
    logic below_term;
    logic below_rechg;
    logic ilim_hit;
    logic vlim_hit;
    logic dp_contact;
    logic dm_sense;
    logic dp_sense;
  } chg_sense_t;
endpackage

//--- hdl/chg_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
module chg_sync #(
  parameter int WIDTH = 1,
  // Level each stage takes in reset: the idle level of each pin.
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_q;

  // Each bit passes its own pair of flops.
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q[i] <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule

//--- hdl/chg_ctrl.sv
// Charger control, status, push-button, detection and monitor logic.
`timescale 1ns/10ps
// Contract
// - Charge only when allowed and enable pin low.
// - Boost only when allowed, requested, no supply.
// - Indicator low while charging, released otherwise.
// - Indicator blinks at 1 Hz on fault.
// - Disable bit stops driving the indicator.
// - Alert pulses low 256 us on events.
// - Autonomous cycle: pre, constant current, voltage.
// - Terminate in CV when current below limit.
// - Restart cycle below recharge threshold.
// - Reduce current above thermal threshold.
// - Input limit zeroes current, battery supplements.
// - Hold load rail above programmable minimum.
// - Monitor converter with 7-bit results.
// - Push button controls the battery switch.
// - Data contact, primary, secondary source detection.
// - Default input limit from detected source.
// - Adapter voltage request by current pulses.
// - Ship mode exits after one second low.
// - Ten second low without supply, outside ship mode, resets rail for 0.3 s.
module chg_ctrl
  import chg_pkg::*;
#(
  parameter int unsigned ALERT_N = ALERT_CYC,
  parameter int unsigned SHIP_EXIT_N = SHIP_EXIT_CYC,
  parameter int unsigned PB_RESET_N = PB_RESET_CYC,
  parameter int unsigned SW_OFF_N = SW_OFF_CYC,
  parameter int unsigned BLINK_N = BLINK_HALF_CYC,
  parameter int unsigned DET_N = DET_STEP_CYC,
  parameter int NCH = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analog flags from outside the clock domain.
  input wire logic charge_enable_n,
  input wire logic boost_request_pin,
  input wire logic push_button_n,
  input wire logic [3:0] fault_in,
  input wire chg_sense_t sense,
  // Same-clock monitor front end.
  input wire logic [6:0] junction_temp,
  input wire logic adc_done,
  input wire logic [6:0] adc_data,
  output logic [2:0] adc_ch,
  output logic adc_start,
  // Open-drain indicator and alert, enable low while driving.
  output logic stat_o,
  output logic stat_oe_n,
  output logic alert_o,
  output logic alert_oe_n,
  // Power stage controls.
  output chg_phase_t charge_phase,
  output logic charge_on,
  output logic boost_on,
  output logic therm_reduce,
  output logic current_zero,
  output logic supplement_en,
  output logic [6:0] sys_min_code,
  output logic sys_hold_req,
  output logic [7:0] input_limit_code,
  output logic battery_switch,
  // USB data line detection and adapter request.
  output logic dp_src_on,
  output logic dm_src_on,
  output logic usb_switch_select,
  output logic pulse_draw
);
  // Synchronised pins.
  logic ce_n_s, boost_req_s, pb_n_s;
  logic [3:0] fault_s;
  chg_sense_t sense_s;
  // Software registers.
  logic [4:0] ctrl_q;
  logic [6:0] therm_q;
  logic [6:0] adc_res_q [NCH];
  // Internal state.
  chg_phase_t phase_q;
  chg_det_t det_q;
  chg_src_t src_q;
  logic [31:0] det_cnt_q, alert_cnt_q, blink_cnt_q, pb_cnt_q, off_cnt_q;
  logic [31:0] hv_cnt_q;
  logic [2:0] hv_left_q;
  logic blink_q, alert_act_q, ship_q, sw_off_q, pb_fired_q, adc_busy_q;
  logic fault_q;
  chg_phase_t phase_prev_q;
  chg_src_t src_prev_q;
  logic fault_any, chg_en, wr, rd_setup, event_now;

  // All asynchronous inputs pass two flops as one group.
  // Stages reset to idle pin levels, so no false fault edge follows reset.
  chg_sync #(.WIDTH(17), .RST_VAL(17'h14000)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({charge_enable_n, boost_request_pin, push_button_n, fault_in, sense}),
    .q({ce_n_s, boost_req_s, pb_n_s, fault_s, sense_s})
  );

  // Fault summary and charge permission.
  assign fault_any = |fault_s;
  // The enable pin is assumed driven to a level, never floating.
  assign chg_en = ctrl_q[CTRL_CHG_BIT] & ~ce_n_s & sense_s.supply_ok &
                  ~fault_any;

  // APB is answered without wait states; read data is latched at setup.
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // Unmapped offsets answer with an error in the access phase.
  assign pslverr = psel & penable & (paddr[1:0] != 2'b00 ||
                   paddr > REG_HVREQ);

  // Control and threshold registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      therm_q <= THERM_RST;
      sys_min_code <= SYSMIN_RST;
    end else if (wr) begin
      if (paddr == REG_CTRL) begin
        ctrl_q <= pwdata[4:0];
      end
      if (paddr == REG_THERM) begin
        therm_q <= pwdata[6:0];
      end
      if (paddr == REG_SYSMIN) begin
        sys_min_code <= pwdata[6:0];
      end
    end
  end

  // Read mux, sampled in the setup cycle so prdata comes from a flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= 32'h0;
      case (paddr)
        REG_CTRL: prdata[4:0] <= ctrl_q;
        REG_STATUS: prdata[11:0] <= {src_q, sense_s.supply_ok,
          battery_switch, ship_q, fault_any, boost_on, charge_on,
          blink_q, phase_q};
        REG_THERM: prdata[6:0] <= therm_q;
        REG_SYSMIN: prdata[6:0] <= sys_min_code;
        REG_HVREQ: prdata[2:0] <= hv_left_q;
        default: begin
          if (paddr >= REG_ADC && paddr < REG_HVREQ) begin
            prdata[6:0] <= adc_res_q[3'(paddr[4:2] - 3'h4)];
          end
        end
      endcase
    end
  end

  // Autonomous charge cycle; the phase follows the battery flags.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= PH_IDLE;
    end else if (!chg_en) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          // Start without software; pick the phase from the cell.
          if (sense_s.below_pre) begin
            phase_q <= PH_PRE;
          end else if (sense_s.below_cv) begin
            phase_q <= PH_CC;
          end else begin
            phase_q <= PH_CV;
          end
        end
        PH_PRE: if (!sense_s.below_pre) phase_q <= PH_CC;
        PH_CC: if (!sense_s.below_cv) phase_q <= PH_CV;
        PH_CV: if (sense_s.below_term) phase_q <= PH_DONE;
        PH_DONE: begin
          // A full cell that sags starts a fresh cycle.
          if (sense_s.below_rechg) begin
            phase_q <= sense_s.below_pre ? PH_PRE : PH_CC;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Registered power stage controls.
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_on <= 1'b0;
      boost_on <= 1'b0;
      therm_reduce <= 1'b0;
      current_zero <= 1'b0;
      supplement_en <= 1'b0;
      sys_hold_req <= 1'b0;
    end else begin
      charge_on <= phase_q inside {PH_PRE, PH_CC, PH_CV};
      boost_on <= ctrl_q[CTRL_BOOST_BIT] & boost_req_s &
                  ~sense_s.supply_ok;
      therm_reduce <= junction_temp > therm_q;
      // Source overload zeroes the charge current and enables the supplement together.
      current_zero <= sense_s.ilim_hit | sense_s.vlim_hit;
      supplement_en <= sense_s.ilim_hit | sense_s.vlim_hit;
      // Ask the converter to lift the rail when it sags.
      sys_hold_req <= adc_res_q[2] < sys_min_code;
    end
  end
  assign charge_phase = phase_q;

  // Fault blink: equal half periods, restarted when faults clear.
  always_ff @(posedge clk) begin
    if (rst || !fault_any) begin
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_N - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // Indicator pin: pulls low while charging or in the blink low half.
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_oe_n <= 1'b1;
    end else if (ctrl_q[CTRL_STATDIS_BIT]) begin
      stat_oe_n <= 1'b1;
    end else if (fault_any) begin
      stat_oe_n <= ~blink_q;
    end else begin
      stat_oe_n <= ~charge_on;
    end
  end
  assign stat_o = 1'b0;
  assign alert_o = 1'b0;

  // Status change and fault edge detection for the alert.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_prev_q <= PH_IDLE;
      src_prev_q <= SRC_NONE;
      fault_q <= 1'b0;
    end else begin
      phase_prev_q <= phase_q;
      src_prev_q <= src_q;
      fault_q <= fault_any;
    end
  end
  assign event_now = (phase_q != phase_prev_q) || (src_q != src_prev_q) ||
                     (fault_any && !fault_q);

  // Alert pulse; events during a pulse merge into it, by design.
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_act_q <= 1'b0;
      alert_cnt_q <= 32'h0;
    end else if (!alert_act_q) begin
      alert_act_q <= event_now;
      alert_cnt_q <= 32'h0;
    end else if (alert_cnt_q == ALERT_N - 1) begin
      alert_act_q <= 1'b0;
    end else begin
      alert_cnt_q <= alert_cnt_q + 32'h1;
    end
  end
  assign alert_oe_n = ~alert_act_q;

  // Push-button low time, counted once per press.
  always_ff @(posedge clk) begin
    if (rst || pb_n_s) begin
      pb_cnt_q <= 32'h0;
    end else if (pb_cnt_q != PB_RESET_N) begin
      pb_cnt_q <= pb_cnt_q + 32'h1;
    end
  end

  // Ship mode and rail reset sequence of the battery switch.
  always_ff @(posedge clk) begin
    if (rst) begin
      ship_q <= 1'b0;
      sw_off_q <= 1'b0;
      off_cnt_q <= 32'h0;
      pb_fired_q <= 1'b0;
    end else begin
      if (pb_n_s) begin
        pb_fired_q <= 1'b0;
      end
      if (wr && paddr == REG_CTRL && pwdata[CTRL_SHIP_BIT]) begin
        ship_q <= 1'b1;
      end else if (ship_q && pb_cnt_q == SHIP_EXIT_N - 1) begin
        ship_q <= 1'b0;
        pb_fired_q <= 1'b1;
      end
      if (sw_off_q) begin
        off_cnt_q <= off_cnt_q + 32'h1;
        if (off_cnt_q == SW_OFF_N - 1) begin
          sw_off_q <= 1'b0;
        end
      end else if (!ship_q && !pb_fired_q && !sense_s.supply_ok &&
                   pb_cnt_q == PB_RESET_N - 1) begin
        sw_off_q <= 1'b1;
        off_cnt_q <= 32'h0;
        pb_fired_q <= 1'b1;
      end
    end
  end
  assign battery_switch = ~ship_q & ~sw_off_q;

  // Source detection on the data lines after the supply appears.
  always_ff @(posedge clk) begin
    if (rst || !sense_s.supply_ok) begin
      det_q <= DT_IDLE;
      src_q <= SRC_NONE;
      det_cnt_q <= 32'h0;
    end else begin
      det_cnt_q <= det_cnt_q + 32'h1;
      case (det_q)
        DT_IDLE: begin
          det_q <= DT_DCD;
          det_cnt_q <= 32'h0;
        end
        DT_DCD: begin
          // Data contact, or give up after one step.
          if (sense_s.dp_contact || det_cnt_q == DET_N - 1) begin
            det_q <= DT_PRI;
            det_cnt_q <= 32'h0;
          end
        end
        DT_PRI: begin
          if (det_cnt_q == DET_N - 1) begin
            det_cnt_q <= 32'h0;
            if (!sense_s.dm_sense) begin
              src_q <= SRC_SDP;
              det_q <= DT_DONE;
            end else begin
              det_q <= DT_SEC;
            end
          end
        end
        DT_SEC: begin
          if (det_cnt_q == DET_N - 1) begin
            src_q <= sense_s.dp_sense ? SRC_DCP : SRC_CDP;
            det_q <= DT_DONE;
          end
        end
        DT_DONE: det_cnt_q <= 32'h0;
        default: det_q <= DT_IDLE;
      endcase
    end
  end

  // Detection drive and default input limit.
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_src_on <= 1'b0;
      dm_src_on <= 1'b0;
      usb_switch_select <= 1'b0;
      input_limit_code <= ILIM_NONE;
    end else begin
      dp_src_on <= det_q == DT_PRI;
      dm_src_on <= det_q == DT_SEC;
      // Lines go back to the USB path once detection is over, unless a dedicated charger was found.
      usb_switch_select <= det_q == DT_DONE && src_q != SRC_DCP;
      case (src_q)
        SRC_SDP: input_limit_code <= ILIM_SDP;
        SRC_CDP: input_limit_code <= ILIM_CDP;
        SRC_DCP: input_limit_code <= ILIM_DCP;
        default: input_limit_code <= ILIM_NONE;
      endcase
    end
  end

  // Adapter request: software writes a pulse count, each pulse and gap
  // lasting one detection step; only a dedicated charger is asked.
  always_ff @(posedge clk) begin
    if (rst) begin
      hv_left_q <= 3'h0;
      hv_cnt_q <= 32'h0;
      pulse_draw <= 1'b0;
    end else if (wr && paddr == REG_HVREQ && src_q == SRC_DCP) begin
      hv_left_q <= pwdata[2:0];
      hv_cnt_q <= 32'h0;
    end else if (hv_left_q != 3'h0) begin
      hv_cnt_q <= hv_cnt_q + 32'h1;
      pulse_draw <= hv_cnt_q < DET_N;
      if (hv_cnt_q == 2 * DET_N - 1) begin
        hv_cnt_q <= 32'h0;
        hv_left_q <= hv_left_q - 3'h1;
      end
    end else begin
      pulse_draw <= 1'b0;
    end
  end

  // Monitor converter: channels in turn while enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_ch <= 3'h0;
      adc_busy_q <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (!adc_busy_q && ctrl_q[CTRL_ADC_BIT]) begin
        adc_start <= 1'b1;
        adc_busy_q <= 1'b1;
      end else if (adc_busy_q && adc_done) begin
        adc_busy_q <= 1'b0;
        adc_ch <= (adc_ch == 3'(NCH - 1)) ? 3'h0 : adc_ch + 3'h1;
      end
    end
  end

  // One 7-bit result register per channel.
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_res
    always_ff @(posedge clk) begin
      if (rst) begin
        adc_res_q[g] <= 7'h0;
      end else if (adc_busy_q && adc_done && adc_ch == 3'(g)) begin
        adc_res_q[g] <= adc_data;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cv_low;
    phase_q == PH_CV && sense_s.below_term && chg_en;
  endsequence
  sequence s_rechg;
    phase_q == PH_DONE && sense_s.below_rechg && chg_en;
  endsequence
  AST_CHG_GATE: assert property (
    charge_on |-> $past(ctrl_q[CTRL_CHG_BIT] && !ce_n_s, 2))
    else $error("charging without permission");
  AST_BOOST: assert property (
    boost_on |-> $past(ctrl_q[CTRL_BOOST_BIT] && !sense_s.supply_ok))
    else $error("boost with supply present");
  AST_STAT_CHG: assert property (
    charge_on && !fault_any && !ctrl_q[CTRL_STATDIS_BIT] |=> !stat_oe_n)
    else $error("indicator not low while charging");
  AST_INDICATOR_DISABLE_BIT: assert property (
    ctrl_q[CTRL_STATDIS_BIT] |=> stat_oe_n)
    else $error("indicator driven while disabled");
  AST_BLINK: assert property (
    $changed(blink_q) && fault_any |-> $past(blink_cnt_q) == BLINK_N - 1)
    else $error("blink half period wrong");
  AST_ALERT_LEN: assert property (
    $rose(alert_oe_n) |-> $past(alert_cnt_q) == ALERT_N - 1)
    else $error("alert pulse length wrong");
  AST_ALERT_FAULT: assert property (
    fault_any && !fault_q && alert_oe_n |=> !alert_oe_n)
    else $error("fault did not raise alert");
  AST_TERM: assert property (
    s_cv_low |=> phase_q == PH_DONE ##1 !charge_on)
    else $error("no termination in constant voltage");
  AST_RECHG: assert property (
    s_rechg |=> phase_q != PH_DONE ##1 charge_on)
    else $error("no recharge below threshold");
  AST_THERM: assert property (
    junction_temp > therm_q |=> therm_reduce)
    else $error("no thermal reduction");
  AST_ILIM: assert property (
    sense_s.ilim_hit |=> current_zero && supplement_en)
    else $error("input limit not honoured");
  AST_SHIP: assert property (
    ship_q && pb_cnt_q == SHIP_EXIT_N - 1 && !pb_n_s
      && !(wr && paddr == REG_CTRL) |=> battery_switch)
    else $error("ship exit failed");
  AST_ILIM_SRC: assert property (
    src_q == SRC_CDP |=> input_limit_code == ILIM_CDP)
    else $error("limit does not follow source");
endmodule

//--- tb/chg_src_model.sv
// Model of the input source data lines and of the monitor converter.
`timescale 1ns/10ps
module chg_src_model
  import chg_pkg::*;
#(
  parameter int DLY = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Source kind and the probe sources of the detection.
  input wire chg_src_t kind,
  input wire logic dp_src_on,
  input wire logic dm_src_on,
  output logic dp_contact,
  output logic dm_sense,
  output logic dp_sense,
  // Converter handshake.
  input wire logic adc_start,
  input wire logic [2:0] adc_ch,
  output logic adc_done,
  output logic [6:0] adc_data
);
  int cnt; // Cycles left until the result is ready.
  logic [2:0] ch_q; // Channel captured at the start pulse.
  // A charging host port echoes the probe back; only a dedicated charger port shorts the lines.
  assign dp_contact = (kind != SRC_NONE);
  assign dm_sense = dp_src_on && (kind inside {SRC_CDP, SRC_DCP});
  assign dp_sense = dm_src_on && (kind == SRC_DCP);
  // Slow answer; data churns between results so a stale read cannot match.
  always_ff @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (rst) begin
      cnt <= 0;
      adc_data <= 7'h00;
    end else if (adc_start) begin
      cnt <= DLY;
      ch_q <= adc_ch;
    end else if (cnt == 1) begin
      cnt <= 0;
      adc_done <= 1'b1;
      adc_data <= {4'h5, ch_q};
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- tb/tb_charger_control_status_logic.sv
// Self-checking testbench of the charger control logic.
`timescale 1ns/10ps
module tb_charger_control_status_logic
  import chg_pkg::*;
;
  // Shortened counts handed to the design; expectations use the same.
  localparam int AL = 16;
  localparam int BL = 20;
  localparam int OFF = 30;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic ce_n = 1'b1, bpin = 1'b0, pb_n = 1'b1;
  logic [3:0] fault = 4'h0;
  logic [6:0] flags = 7'h00; // Supply, pre, cv, term, rechg, ilim, vlim.
  logic [6:0] jt = 7'h00, adc_data, sys_min;
  chg_src_t kind = SRC_NONE;
  chg_phase_t phase;
  logic dpc, dms, dps, adc_done, adc_start, stat_oe_n, alert_oe_n;
  logic charge_on, boost_on, therm_reduce, current_zero, supplement_en;
  logic bsw, dp_on, dm_on, pdraw, shr, uss;
  logic [2:0] adc_ch;
  logic [7:0] ilim;
  chg_sense_t sense;
  int miscompares = 0, samples_checked = 0, i, n;
  // Rows: chg allow, boost allow, ce_n, boost pin, supply | charge, boost.
  logic [6:0] rows[7] = '{7'b1100110, 7'b0100100, 7'b1110100,
    7'b1101110, 7'b1101001, 7'b1001000, 7'b1100000};
  // Steps of a charge cycle: flags, phase, indicator enable.
  logic [10:0] steps[5] = '{{7'h60, PH_PRE, 1'b0}, {7'h50, PH_CC, 1'b0},
    {7'h40, PH_CV, 1'b0}, {7'h48, PH_DONE, 1'b1}, {7'h54, PH_CC, 1'b0}};
  logic [7:0] lims[4] = '{ILIM_NONE, ILIM_SDP, ILIM_CDP, ILIM_DCP};
  assign sense = {flags, dpc, dms, dps};
  always #5 clk = ~clk;
  chg_ctrl #(.ALERT_N(AL), .SHIP_EXIT_N(50), .PB_RESET_N(200),
    .SW_OFF_N(OFF), .BLINK_N(BL), .DET_N(8)) chg_ctrl_i (.clk(clk),
    .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .charge_enable_n(ce_n), .boost_request_pin(bpin),
    .push_button_n(pb_n), .fault_in(fault), .sense(sense),
    .junction_temp(jt), .adc_done(adc_done), .adc_data(adc_data),
    .adc_ch(adc_ch), .adc_start(adc_start), .stat_o(), .stat_oe_n(stat_oe_n),
    .alert_o(), .alert_oe_n(alert_oe_n), .charge_phase(phase),
    .charge_on(charge_on), .boost_on(boost_on), .therm_reduce(therm_reduce),
    .current_zero(current_zero), .supplement_en(supplement_en),
    .sys_min_code(sys_min), .sys_hold_req(shr), .input_limit_code(ilim),
    .battery_switch(bsw), .dp_src_on(dp_on), .dm_src_on(dm_on),
    .usb_switch_select(uss), .pulse_draw(pdraw));
  chg_src_model chg_src_model_i (.clk(clk), .rst(rst), .kind(kind),
    .dp_src_on(dp_on), .dm_src_on(dm_on), .dp_contact(dpc), .dm_sense(dms),
    .dp_sense(dps), .adc_start(adc_start), .adc_ch(adc_ch),
    .adc_done(adc_done), .adc_data(adc_data));
  // Compares one value and counts it; a mismatch is reported at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? alert_oe_n : (w == 1 ? stat_oe_n : bsw);
  endfunction
  // Length of the next whole low stretch; a partial one is skipped first.
  task automatic low_len(input int w, input int bound, output int len);
    int t;
    t = 0;
    len = 0;
    while (pick(w) === 1'b0 && t < bound) begin @(posedge clk); t++; end
    while (pick(w) !== 1'b0 && t < bound) begin @(posedge clk); t++; end
    while (pick(w) === 1'b0 && len < 400) begin @(posedge clk); len++; end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // The whole run takes about a thousand cycles; this cuts a hang short.
  initial begin
    cyc(20000);
    miscompares++;
    give_verdict;
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    @(posedge clk);
    chk(stat_oe_n, 1'b1);
    chk(bsw, 1'b1);
    chk(ilim, ILIM_NONE);
    chk(sys_min, SYSMIN_RST);
    apb(1'b0, REG_THERM, 32'h0);
    chk(rdat, THERM_RST);
    apb(1'b0, 8'h28, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    for (i = 0; i < 7; i++) begin
      apb(1'b1, REG_CTRL, {27'h0, 3'b100, rows[i][5], rows[i][6]});
      ce_n <= rows[i][4]; // Always a level, never floating.
      bpin <= rows[i][3];
      flags <= {rows[i][2], 6'h10};
      cyc(12);
      chk(charge_on, rows[i][1]);
      chk(boost_on, rows[i][0]);
      chk(stat_oe_n, !rows[i][1]);
    end
    // Full cycle: pre, constant current, voltage, end, then a recharge.
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      flags <= steps[i][10:4];
      cyc(10);
      chk(phase, steps[i][3:1]);
      chk(stat_oe_n, steps[i][0]);
    end
    jt <= 7'h79;
    cyc(5);
    chk(therm_reduce, 1'b1);
    jt <= 7'h78;
    cyc(5);
    chk(therm_reduce, 1'b0);
    flags <= 7'h52;
    cyc(6);
    chk({current_zero, supplement_en}, 2'b11);
    flags <= 7'h50;
    chk(shr, 1'b0);
    apb(1'b1, REG_SYSMIN, 32'h30);
    cyc(2);
    chk(sys_min, 7'h30);
    chk(shr, 1'b1);
    apb(1'b0, REG_ADC, 32'h0);
    chk(rdat, {4'h5, 3'h0});
    apb(1'b0, 8'h20, 32'h0);
    chk(rdat, {4'h5, 3'h4});
    // Each source kind is plugged in anew and sets its own default limit.
    for (i = 1; i < 4; i++) begin
      flags <= 7'h00;
      cyc(10);
      kind <= chg_src_t'(i);
      flags <= 7'h50;
      cyc(80);
      chk(ilim, lims[i]);
      chk(uss, i < 3);
    end
    apb(1'b1, REG_HVREQ, 32'h2);
    n = 0;
    repeat (100) begin @(posedge clk); if (pdraw === 1'b1) n++; end
    chk(n, 16);
    fault <= 4'h1;
    low_len(0, 10, n);
    chk(n, AL);
    low_len(1, 60, n);
    chk(n, BL);
    n = 0;
    while (stat_oe_n === 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk(n, BL);
    apb(1'b1, REG_CTRL, 32'h15);
    // The pin flop takes the disable one edge after the write lands.
    cyc(1);
    n = 0;
    repeat (50) begin @(posedge clk); if (stat_oe_n !== 1'b1) n++; end
    chk(n, 0);
    fault <= 4'h0;
    apb(1'b1, REG_CTRL, 32'h19);
    cyc(4);
    chk(bsw, 1'b0);
    pb_n <= 1'b0;
    cyc(60);
    chk(bsw, 1'b1);
    pb_n <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h11);
    flags <= 7'h00;
    cyc(5);
    pb_n <= 1'b0;
    low_len(2, 300, n);
    chk(n, OFF);
    pb_n <= 1'b1;
    give_verdict;
  end
endmodule
